// ===== rtl/pmc_pkg.sv
// Constants and types shared by the passage mode controller.
// Assumes a single 20 MHz system clock; all second-scale times derive from it.
package pmc_pkg;
    // ********************************************************************
    // Timing.
    // ********************************************************************
    localparam int unsigned CLK_HZ       = 20_000_000;
    localparam int unsigned TICK_S       = 1;
    localparam int unsigned TICK_CYCLES  = CLK_HZ * TICK_S;
    localparam int unsigned WAIT_S       = 5;
    localparam int unsigned PAUSE_S      = 3;
    localparam int unsigned EMERG_S      = 10;
    localparam int unsigned TONE_S       = 2;
    localparam logic [7:0]  WAIT_TICKS   = 8'(WAIT_S / TICK_S);
    localparam logic [3:0]  PAUSE_TICKS  = 4'(PAUSE_S / TICK_S);
    localparam logic [3:0]  EMERG_TICKS  = 4'(EMERG_S / TICK_S);
    localparam logic [1:0]  TONE_TICKS   = 2'(TONE_S / TICK_S);

    // ********************************************************************
    // Register map (byte addresses) and fields.
    // ********************************************************************
    localparam logic [4:0] OFS_CMD   = 5'h00;
    localparam logic [4:0] OFS_STAT  = 5'h04;
    localparam logic [4:0] OFS_IRQ   = 5'h08;
    localparam logic [4:0] OFS_MASK  = 5'h0c;
    localparam logic [4:0] OFS_WAIT  = 5'h10;
    localparam logic [2:0] CMD_LOCK  = 3'h4;
    localparam int         EV_PASS   = 0;
    localparam int         EV_EXPIRE = 1;
    localparam int         EV_BLOCK  = 2;
    localparam int         EV_EMERG  = 3;
    localparam int         NEV       = 4;

    // Rotation states, Gray coded along idle, rotate, pause, emergency.
    typedef enum logic [1:0] {
        PMC_IDLE  = 2'b00,
        PMC_ROT   = 2'b01,
        PMC_PAUSE = 2'b11,
        PMC_EMERG = 2'b10
    } pmc_rot_t;
endpackage : pmc_pkg

// ===== rtl/pmc_top.sv
// Passage mode controller for a rotor turnstile control unit.
// Assumes buttons and rotor sensors are synchronous to sys_clk and debounced.
// Notes on behaviour
// - At power-up light mains and supply lamps, sound two tones, light stop lamp.
// - After reset the turnstile is closed, rotation blocked both ways.
// - Stop alone selects locked mode; drive returns barrier to rest.
// - One button single; both single bidirectional; stop plus direction free.
// - Single mode releases only chosen lock for a five second wait.
// - A fifteen degree turn counts as passage; drive completes the turn.
// - Wait expiry without passage closes the lock and locks the turnstile.
// - Each direction has its own independent wait countdown.
// - Bidirectional: after one passage the other way restarts its wait.
// - Non-stop commands during a rotation cycle go to the command queue.
// - At rest the queued command runs automatically.
// - Free mode returns barrier after each turn without timing a wait.
// - Opposite button in free mode adds one single passage, then reverts.
// - First forced block pauses the drive three seconds, then resumes.
// - Second block starts ten second emergency with blinking and sound.
// - After emergency single modes lock; free modes return to prior mode.
// - Stop during emergency cancels it.
// - Locked lights both red and stop lamps; open directions light green.
`timescale 1ns/1ps
module pmc_top #(
    parameter int unsigned TICK_CYCLES = pmc_pkg::TICK_CYCLES
) (
    input  wire logic        sys_clk,
    input  wire logic        rstn,
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    output logic             irq,
    input  wire logic        btn_right,
    input  wire logic        btn_left,
    input  wire logic        btn_stop,
    input  wire logic        pass_right,
    input  wire logic        pass_left,
    input  wire logic        rotor_at_rest,
    input  wire logic        rotor_blocked,
    output logic             lock_right_release,
    output logic             lock_left_release,
    output logic             drive_run,
    output logic             drive_dir_left,
    output logic             left_locked_lamp_out,
    output logic             right_locked_lamp_out,
    output logic             left_open_lamp_out,
    output logic             right_open_lamp_out,
    output logic             stop_lamp_out,
    output logic             mains_lamp_out,
    output logic             supply_lamp_out,
    output logic             sound_out,
    output logic             sound_high
);
    // ********************************************************************
    // Declarations.
    // ********************************************************************
    pmc_pkg::pmc_rot_t state_reg, state_next;
    logic [31:0]     pre_reg;
    logic            tick;
    logic            blink_reg;
    logic [1:0]      tone_reg;
    logic            lamps_reg;
    logic [2:0]      seen_reg;
    logic [2:0]      q_cmd_reg;
    logic            q_valid_reg;
    logic [1:0]      free_reg, free_next;
    logic [1:0]      single_reg, single_next;
    logic [1:0]      restart;
    logic [1:0]      expire;
    logic [1:0]      open_mask;
    logic [7:0]      wait_cnt_reg [2];
    logic [7:0]      wait_reg;
    logic [3:0]      tcnt_reg;
    logic            dir_reg;
    logic            blk_seen_reg;
    logic            em_seen_reg;
    localparam int   NEV_W = pmc_pkg::NEV;
    logic [NEV_W-1:0] irq_stat_reg, irq_mask_reg, events;
    logic            ack_reg;
    logic [31:0]     rdata_reg;

    // ********************************************************************
    // Prescaler and blink base.
    // ********************************************************************
    // One tick per second keeps every long interval a small counter.
    assign tick = (pre_reg == 32'(TICK_CYCLES - 1));

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            pre_reg   <= 32'h0;
            blink_reg <= 1'b0;
        end else begin
            pre_reg   <= tick ? 32'h0 : pre_reg + 32'h1;
            blink_reg <= blink_reg ^ tick;
        end
    end

    // ********************************************************************
    // Command capture from panel buttons and software.
    // ********************************************************************
    // A panel command is the union of buttons held, taken on full release,
    // so slightly skewed simultaneous presses still form one combination.
    wire [2:0] btn_now    = {btn_stop, btn_left, btn_right};
    wire       panel_cmd  = (btn_now == 3'h0) && (seen_reg != 3'h0);
    wire       req        = avs_read | avs_write;
    wire       accept     = req & ack_reg;
    wire       wr_cmd     = accept && avs_write && (avs_address == pmc_pkg::OFS_CMD);
    wire       sw_cmd     = wr_cmd && (avs_writedata[2:0] != 3'h0);
    wire       cmd_valid  = panel_cmd | sw_cmd;
    wire [2:0] cmd_bits   = panel_cmd ? seen_reg : avs_writedata[2:0];
    wire       stop_now   = cmd_valid && (cmd_bits == pmc_pkg::CMD_LOCK);
    wire       idle       = (state_reg == pmc_pkg::PMC_IDLE);
    wire       completing = (state_reg == pmc_pkg::PMC_ROT) && rotor_at_rest;
    wire       from_q     = completing && (q_valid_reg || cmd_valid);
    wire [2:0] ap_cmd     = (from_q && !cmd_valid) ? q_cmd_reg : cmd_bits;
    wire       ap_en      = from_q || (cmd_valid && idle && !stop_now);
    wire       odir       = !dir_reg;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            seen_reg <= 3'h0;
        end else begin
            seen_reg <= panel_cmd ? 3'h0 : (seen_reg | btn_now);
        end
    end

    // Queue holds one command; a later one replaces it, stop empties it.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            q_valid_reg <= 1'b0;
            q_cmd_reg   <= 3'h0;
        end else if (stop_now) begin
            q_valid_reg <= 1'b0;
        end else if (completing) begin
            q_valid_reg <= 1'b0;
        end else if (cmd_valid && !idle) begin
            q_valid_reg <= 1'b1;
            q_cmd_reg   <= cmd_bits;
        end
    end

    // ********************************************************************
    // Mode masks: free and single passage per direction (0 right, 1 left).
    // ********************************************************************
    assign open_mask = free_reg | single_reg;

    always_comb begin
        free_next   = free_reg;
        single_next = single_reg;
        restart     = 2'b00;
        if (completing) begin
            single_next[dir_reg] = 1'b0;
            if (single_reg[odir]) begin
                restart[odir] = 1'b1;
            end
            if (em_seen_reg) begin
                single_next = 2'b00;
            end
        end
        single_next = single_next & ~expire;
        if (ap_en) begin
            if (ap_cmd[2]) begin
                free_next   = ap_cmd[1:0];
                single_next = 2'b00;
            end else if ((free_next != 2'b00) && ((ap_cmd[1:0] & free_next) == 2'b00)) begin
                single_next = ap_cmd[1:0];
                restart     = ap_cmd[1:0];
            end else begin
                free_next   = 2'b00;
                single_next = ap_cmd[1:0];
                restart     = ap_cmd[1:0];
            end
        end
        if (stop_now) begin
            free_next   = 2'b00;
            single_next = 2'b00;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            free_reg   <= 2'b00;
            single_reg <= 2'b00;
        end else begin
            free_reg   <= free_next;
            single_reg <= single_next;
        end
    end

    // ********************************************************************
    // Passage wait countdown, one per direction.
    // ********************************************************************
    // Free directions never load a count, so they are never timed.
    genvar d;
    generate
        for (d = 0; d < 2; d++) begin : g_wait
            assign expire[d] = tick && idle && single_reg[d]
                               && (wait_cnt_reg[d] == 8'h01);
            always_ff @(posedge sys_clk or negedge rstn) begin
                if (!rstn) begin
                    wait_cnt_reg[d] <= 8'h00;
                end else if (restart[d]) begin
                    wait_cnt_reg[d] <= wait_reg;
                end else if (tick && idle && single_reg[d] && wait_cnt_reg[d] != 8'h00) begin
                    wait_cnt_reg[d] <= wait_cnt_reg[d] - 8'h01;
                end
            end
        end
    endgenerate

    // ********************************************************************
    // Rotation cycle: rotate, pause after a block, emergency after two.
    // ********************************************************************
    wire tdone = tick && (tcnt_reg == 4'h1);

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            pmc_pkg::PMC_IDLE: begin
                if ((pass_right && open_mask[0]) || (pass_left && open_mask[1])) begin
                    state_next = pmc_pkg::PMC_ROT;
                end
            end
            pmc_pkg::PMC_ROT: begin
                if (rotor_at_rest) begin
                    state_next = pmc_pkg::PMC_IDLE;
                end else if (rotor_blocked) begin
                    state_next = blk_seen_reg ? pmc_pkg::PMC_EMERG : pmc_pkg::PMC_PAUSE;
                end
            end
            pmc_pkg::PMC_PAUSE: begin
                if (tdone) begin
                    state_next = pmc_pkg::PMC_ROT;
                end
            end
            default: begin
                if (tdone || stop_now) begin
                    state_next = pmc_pkg::PMC_ROT;
                end
            end
        endcase
    end

    wire enter_pause = (state_next == pmc_pkg::PMC_PAUSE) && !blk_seen_reg;
    wire enter_emerg = (state_next == pmc_pkg::PMC_EMERG) && (state_reg == pmc_pkg::PMC_ROT);

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state_reg    <= pmc_pkg::PMC_IDLE;
            dir_reg      <= 1'b0;
            tcnt_reg     <= 4'h0;
            blk_seen_reg <= 1'b0;
            em_seen_reg  <= 1'b0;
        end else begin
            state_reg <= state_next;
            if (idle) begin
                dir_reg      <= !(pass_right && open_mask[0]);
                blk_seen_reg <= 1'b0;
                em_seen_reg  <= 1'b0;
            end
            if (enter_pause) begin
                tcnt_reg     <= pmc_pkg::PAUSE_TICKS;
                blk_seen_reg <= 1'b1;
            end else if (enter_emerg) begin
                tcnt_reg    <= pmc_pkg::EMERG_TICKS;
                em_seen_reg <= 1'b1;
            end else if (tick && tcnt_reg != 4'h0) begin
                tcnt_reg <= tcnt_reg - 4'h1;
            end
        end
    end

    // ********************************************************************
    // Drive, locks and indication.
    // ********************************************************************
    wire locked = (open_mask == 2'b00);
    wire emerg  = (state_reg == pmc_pkg::PMC_EMERG);
    wire busy   = !idle;

    assign drive_run             = (state_reg == pmc_pkg::PMC_ROT);
    assign drive_dir_left        = dir_reg;
    assign lock_right_release    = open_mask[0] || (busy && !dir_reg);
    assign lock_left_release     = open_mask[1] || (busy && dir_reg);
    assign right_locked_lamp_out = !open_mask[0];
    assign left_locked_lamp_out  = !open_mask[1];
    assign right_open_lamp_out   = open_mask[0];
    assign left_open_lamp_out    = open_mask[1];
    assign stop_lamp_out         = emerg ? blink_reg : locked;
    assign sound_out             = (tone_reg != 2'h0) || (emerg && blink_reg);
    assign sound_high            = (tone_reg == 2'h1);
    assign mains_lamp_out        = lamps_reg;
    assign supply_lamp_out       = lamps_reg;

    // Two-tone greeting: low tone then high tone, one tick each.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            lamps_reg <= 1'b0;
            tone_reg  <= pmc_pkg::TONE_TICKS;
        end else begin
            lamps_reg <= 1'b1;
            if (tick && tone_reg != 2'h0) begin
                tone_reg <= tone_reg - 2'h1;
            end
        end
    end

    // ********************************************************************
    // Avalon-MM slave with one wait state, interrupt status and mask.
    // ********************************************************************
    // One wait state lets read data settle in a flop before it is sampled.
    assign avs_waitrequest = req & ~ack_reg;
    assign avs_readdata    = rdata_reg;
    assign irq             = |(irq_stat_reg & irq_mask_reg);
    assign events = {enter_emerg, rotor_blocked && drive_run, |expire, completing};

    wire [31:0] stat_word = {23'h0, state_reg, dir_reg, em_seen_reg, q_valid_reg,
                             single_reg, free_reg};
    wire [31:0] rd_mux = (avs_address == pmc_pkg::OFS_CMD)  ? 32'h0 :
                         (avs_address == pmc_pkg::OFS_STAT) ? stat_word :
                         (avs_address == pmc_pkg::OFS_IRQ)  ? {28'h0, irq_stat_reg} :
                         (avs_address == pmc_pkg::OFS_MASK) ? {28'h0, irq_mask_reg} :
                         (avs_address == pmc_pkg::OFS_WAIT) ? {24'h0, wait_reg} : 32'h0;
    wire rd_clr = accept && avs_read && (avs_address == pmc_pkg::OFS_IRQ);

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ack_reg      <= 1'b0;
            rdata_reg    <= 32'h0;
            irq_stat_reg <= '0;
            irq_mask_reg <= '0;
            wait_reg     <= pmc_pkg::WAIT_TICKS;
        end else begin
            ack_reg <= req & ~ack_reg;
            if (req && !ack_reg && avs_read) begin
                rdata_reg <= rd_mux;
            end
            // A clearing read drops only the bits it reported; new events survive.
            irq_stat_reg <= (rd_clr ? irq_stat_reg & ~rdata_reg[NEV_W-1:0] : irq_stat_reg)
                            | events;
            if (accept && avs_write && avs_address == pmc_pkg::OFS_MASK) begin
                irq_mask_reg <= avs_writedata[NEV_W-1:0];
            end
            if (accept && avs_write && avs_address == pmc_pkg::OFS_WAIT) begin
                wait_reg <= avs_writedata[7:0];
            end
        end
    end

    // ********************************************************************
    // Assertions.
    // ********************************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    a_stop_locks: assert property (stop_now |=> locked && stop_lamp_out)
        else $error("stop did not lock");
    a_locked_lamps: assert property (locked && idle |-> left_locked_lamp_out
        && right_locked_lamp_out && !lock_left_release && !lock_right_release)
        else $error("locked indication wrong");
    a_expire_close: assert property (expire[0] && !ap_en |=> !single_reg[0])
        else $error("wait expiry kept lock open");
    a_queue_hold: assert property (cmd_valid && busy && !completing && !stop_now
        |=> q_valid_reg)
        else $error("command not queued");
    a_queue_run: assert property (from_q && !cmd_valid |=> !q_valid_reg && idle)
        else $error("queued command not run");
    a_pause_hold: assert property (state_reg == pmc_pkg::PMC_PAUSE && !tdone
        |=> state_reg == pmc_pkg::PMC_PAUSE)
        else $error("pause ended early");
    a_emerg_cancel: assert property (emerg && stop_now |=> drive_run && locked)
        else $error("stop did not cancel emergency");
    a_pass_start: assert property (idle && pass_right && open_mask[0]
        |=> drive_run && !drive_dir_left)
        else $error("passage did not start rotation");
    a_wait_restart: assert property (completing && single_reg[odir] && !em_seen_reg
        && !ap_en |=> wait_cnt_reg[$past(odir)] == wait_reg)
        else $error("other direction wait not restarted");
    a_second_block: assert property (drive_run && rotor_blocked && !rotor_at_rest
        && blk_seen_reg |=> emerg && tcnt_reg == pmc_pkg::EMERG_TICKS)
        else $error("second block did not start emergency");
endmodule : pmc_top

// ===== verification/passage_mode_controller_test.sv
// Self-checking bench for the passage mode controller with a one-prescaler-tick of 10 clocks.
// Assumes the rotor model stands at the drive side and the bench plays the panel and host.
`timescale 1ns/1ps
module passage_mode_controller_test;
    logic        sys_clk, rstn, avs_read, avs_write, btn_right, btn_left, btn_stop;
    logic        rotor_blocked, turn_req, turn_left, pass_right, pass_left, rotor_at_rest;
    logic [4:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic        avs_waitrequest, irq, lock_r, lock_l, drive_run, dir_l, red_l, red_r;
    logic        grn_l, grn_r, stop_lamp, mains, supply, sound, sound_hi;
    int          error_cnt, n_compared, cyc;

    pmc_top #(.TICK_CYCLES(10)) uut (.sys_clk(sys_clk), .rstn(rstn),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .irq(irq), .btn_right(btn_right),
        .btn_left(btn_left), .btn_stop(btn_stop), .pass_right(pass_right),
        .pass_left(pass_left), .rotor_at_rest(rotor_at_rest), .rotor_blocked(rotor_blocked),
        .lock_right_release(lock_r), .lock_left_release(lock_l), .drive_run(drive_run),
        .drive_dir_left(dir_l), .left_locked_lamp_out(red_l), .right_locked_lamp_out(red_r),
        .left_open_lamp_out(grn_l), .right_open_lamp_out(grn_r), .stop_lamp_out(stop_lamp),
        .mains_lamp_out(mains), .supply_lamp_out(supply), .sound_out(sound),
        .sound_high(sound_hi));
    pmc_rotor_model rotor (.sys_clk(sys_clk), .rstn(rstn), .drive_run(drive_run),
        .turn_req(turn_req), .turn_left(turn_left), .turn_cycles(8'h28),
        .pass_right(pass_right), .pass_left(pass_left), .rotor_at_rest(rotor_at_rest));

    // ********************************************************************
    // Clock, watchdog and shared tasks.
    // ********************************************************************
    initial sys_clk = 1'b0;
    always #25 sys_clk = ~sys_clk;
    // A hang is cut short well above the several hundred cycles the scenarios need.
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            summarize();
        end
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // One Avalon transfer; the request is held until waitrequest is sampled low.
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        avs_write <= wr;
        avs_read <= ~wr;
        avs_address <= a;
        avs_writedata <= d;
        do begin
            @(posedge sys_clk);
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : bus

    // Press {stop,left,right} for one cycle; the command lands one edge after release.
    task automatic press(input logic [2:0] b);
        @(posedge sys_clk);
        {btn_stop, btn_left, btn_right} <= b;
        @(posedge sys_clk);
        {btn_stop, btn_left, btn_right} <= 3'h0;
        repeat (3) @(posedge sys_clk);
    endtask : press

    // Turn the wing by hand and follow the drive until it reports rest again.
    task automatic turn(input logic left);
        int n;
        @(posedge sys_clk);
        turn_req <= 1'b1;
        turn_left <= left;
        @(posedge sys_clk);
        turn_req <= 1'b0;
        repeat (3) @(posedge sys_clk);
        chk("drive_run", 32'h1, {31'h0, drive_run});
        chk("drive_dir_left", {31'h0, left}, {31'h0, dir_l});
        n = 0;
        while (drive_run !== 1'b0 && n < 100) begin
            @(posedge sys_clk);
            n++;
        end
        chk("drive stopped", 32'h0, {31'h0, drive_run});
        repeat (2) @(posedge sys_clk);
    endtask : turn

    // ********************************************************************
    // Scenarios.
    // ********************************************************************
    task automatic t_reset();
        chk("lamps", 32'h0000_001f,
            {25'h0, grn_l, grn_r, red_l, red_r, stop_lamp, mains, supply});
        chk("tone", 32'h2, {30'h0, sound, sound_hi});
        chk("locks", 32'h0, {29'h0, lock_l, lock_r, drive_run});
        bus(1'b0, 5'h10, 32'h0);
        chk("wait ticks", 32'h5, rd);
        bus(1'b0, 5'h0c, 32'h0);
        chk("mask", 32'h0, rd);
        bus(1'b1, 5'h14, 32'hffff_ffff);
        chk("second tone", 32'h3, {30'h0, sound, sound_hi});
        bus(1'b0, 5'h14, 32'h0);
        chk("unmapped", 32'h0, rd);
    endtask : t_reset

    task automatic t_single();
        press(3'h1);
        chk("right single", 32'h0000_000d, {27'h0, lock_l, lock_r, red_l, red_r, grn_r});
        turn(1'b0);
        chk("relocked", 32'h0, {30'h0, lock_l, lock_r});
        chk("masked irq", 32'h0, {31'h0, irq});
        chk("tone off", 32'h0, {30'h0, sound, sound_hi});
        bus(1'b0, 5'h08, 32'h0);
        chk("irq status", 32'h1, rd);
        bus(1'b0, 5'h08, 32'h0);
        chk("irq cleared", 32'h0, rd);
    endtask : t_single

    task automatic t_expire();
        bus(1'b1, 5'h0c, 32'h2);
        press(3'h2);
        repeat (30) @(posedge sys_clk);
        chk("left still open", 32'h1, {31'h0, lock_l});
        repeat (40) @(posedge sys_clk);
        chk("expired", 32'h3, {29'h0, lock_l, red_l, stop_lamp});
        chk("irq raised", 32'h1, {31'h0, irq});
        bus(1'b0, 5'h08, 32'h0);
        chk("irq status", 32'h2, rd);
        @(posedge sys_clk);
        chk("irq low", 32'h0, {31'h0, irq});
    endtask : t_expire

    task automatic t_bidir();
        press(3'h3);
        chk("both open", 32'hf, {28'h0, lock_l, lock_r, grn_l, grn_r});
        turn(1'b0);
        chk("other open", 32'h2, {30'h0, lock_l, lock_r});
        repeat (30) @(posedge sys_clk);
        chk("wait restarted", 32'h2, {30'h0, lock_l, lock_r});
        repeat (20) @(posedge sys_clk);
        chk("restart expiry", 32'h0, {30'h0, lock_l, lock_r});
        press(3'h4);
    endtask : t_bidir

    task automatic t_free();
        press(3'h6);
        chk("free left", 32'h3, {30'h0, lock_l, grn_l});
        turn(1'b1);
        repeat (70) @(posedge sys_clk);
        chk("still free", 32'h1, {31'h0, lock_l});
        press(3'h1);
        chk("free plus single", 32'h3, {30'h0, lock_l, lock_r});
        press(3'h4);
        chk("stopped", 32'h1c, {27'h0, red_l, red_r, stop_lamp, lock_l, grn_l});
    endtask : t_free

    // A right turn blocked twice: pause, a queued left command, then emergency.
    task automatic t_block();
        press(3'h1);
        turn_req <= 1'b1;
        turn_left <= 1'b0;
        @(posedge sys_clk);
        turn_req <= 1'b0;
        repeat (3) @(posedge sys_clk);
        rotor_blocked <= 1'b1;
        @(posedge sys_clk);
        rotor_blocked <= 1'b0;
        press(3'h2);
        chk("paused", 32'h0, {31'h0, drive_run});
        repeat (30) @(posedge sys_clk);
        chk("resumed", 32'h2, {30'h0, drive_run, dir_l});
        rotor_blocked <= 1'b1;
        @(posedge sys_clk);
        rotor_blocked <= 1'b0;
        bus(1'b0, 5'h04, 32'h0);
        chk("emergency status", 32'h134, rd);
        repeat (140) @(posedge sys_clk);
        chk("queued left", 32'h2, {30'h0, lock_l, lock_r});
    endtask : t_block

    task automatic summarize();
        $display("Compared %0d, errors %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : summarize

    initial begin
        {rstn, avs_read, avs_write, btn_right, btn_left, btn_stop} = 6'h0;
        {rotor_blocked, turn_req, turn_left} = 3'h0;
        avs_address = 5'h00;
        avs_writedata = 32'h0;
        error_cnt = 0;
        n_compared = 0;
        cyc = 0;
        repeat (16) @(posedge sys_clk);
        rstn <= 1'b1;
        repeat (2) @(posedge sys_clk);
        t_reset();
        t_single();
        t_expire();
        t_bidir();
        t_free();
        t_block();
        summarize();
    end
endmodule : passage_mode_controller_test

// ===== verification/pmc_rotor_model.sv
// Behavioural rotor drive and passage sensors for the passage mode controller bench.
// Assumes the bench asks for each turn and that drive_run is a level from the block.
`timescale 1ns/1ps
module pmc_rotor_model (
    input  wire logic       sys_clk,
    input  wire logic       rstn,
    input  wire logic       drive_run,
    input  wire logic       turn_req,
    input  wire logic       turn_left,
    input  wire logic [7:0] turn_cycles,
    output logic            pass_right,
    output logic            pass_left,
    output logic            rotor_at_rest
);
    logic [7:0] cnt_reg;

    // A turn pulses one sensor and leaves rest at once; the wing is back at rest only
    // after the drive has run turn_cycles clocks, so a slow drive is easy to mimic.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            pass_right    <= 1'b0;
            pass_left     <= 1'b0;
            rotor_at_rest <= 1'b1;
            cnt_reg       <= 8'h00;
        end else begin
            pass_right <= turn_req & ~turn_left;
            pass_left  <= turn_req & turn_left;
            if (turn_req) begin
                rotor_at_rest <= 1'b0;
                cnt_reg       <= turn_cycles;
            end else if (drive_run && cnt_reg != 8'h00) begin
                cnt_reg <= cnt_reg - 8'h01;
            end else if (drive_run) begin
                rotor_at_rest <= 1'b1;
            end
        end
    end
endmodule : pmc_rotor_model
